// [pir_phy_id_advert.sv]
// Identifier and auto-negotiation advertisement registers, reached by
// serial management frames on MDC/MDIO.
// Assumes MDC is slow against SYS_CLK_IN and the negotiation engine sits
// on the same clock.
// Contract
// - Two identifier registers form one identifier
// - First register holds org bits 3..18
// - Org code bits 1 and 2 omitted
// - Second register bits 15..10 hold org 19..24
// - Model number in bits 9..4
// - Revision number in bits 3..0
// - Advertisement word feeds the negotiation engine
// - Next page bit reads 0, unwritable
// - Acknowledge bit driven by negotiation engine
// - Bit 13 writable remote fault, reset 0
// - Bit 10 writable flow control, reset 0
// - Four-pair ability bit reads 0, unwritable
// - Bits 8..5 writable abilities, reset 1
// - Selector bits 4..0 writable, reset 00001
// - Access via serial management frames only
`timescale 1ns/1ps
`default_nettype none
module pir_phy_id_advert
  import pir_pkg::*;
#(
  parameter logic [23:0] ORG_CODE  = PIR_ORG_CODE_DEF,
  parameter logic [5:0]  MODEL_NUM = PIR_MODEL_NUM_DEF,
  parameter logic [3:0]  MODEL_REV = PIR_MODEL_REV_DEF,
  parameter logic [4:0]  PHY_ADDR  = PIR_PHY_ADDR_DEF
) (
  // Clock and resets
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        PHY_SOFT_RST_IN,
  // Management pins
  input  wire logic        MDC_IN,
  input  wire logic        MDIO_IN,
  output logic             MDIO_OUT,
  output logic             MDIO_OE_OUT,
  // Negotiation engine side
  input  wire logic        AN_ACK_IN,
  output logic [15:0]      ADV_WORD_OUT
);

  // ----------------------------------------------------------------
  // Identifier words, fixed at build time
  // ----------------------------------------------------------------
  // Org code vector index i carries org bit i+1
  function automatic logic [15:0] id_high_f(input logic [23:0] org);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      r[15-k] = org[PIR_ORG_HIGH_FIRST-1+k];
    end
    return r;
  endfunction : id_high_f

  function automatic logic [15:0] id_low_f(input logic [23:0] org,
                                           input logic [5:0]  mdl,
                                           input logic [3:0]  rev);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < PIR_ORG_LOW_BITS; k++) begin
      r[15-k] = org[PIR_ORG_LOW_FIRST-1+k];
    end
    r[PIR_MODEL_LSB +: 6] = mdl;
    r[PIR_REV_LSB +: 4]   = rev;
    return r;
  endfunction : id_low_f

  // Both words read through one path so they form one identifier
  logic [15:0] id_high_w;
  logic [15:0] id_low_w;
  assign id_high_w = id_high_f(ORG_CODE);
  assign id_low_w  = id_low_f(ORG_CODE, MODEL_NUM, MODEL_REV);

  // Advertisement word, shared by the read path and the engine output
  function automatic logic [15:0] adv_word_f(input logic       ack,
                                             input logic       rf,
                                             input logic [1:0] rsv,
                                             input logic       fc,
                                             input logic [3:0] abil,
                                             input logic [4:0] sel);
    logic [15:0] r;
    r = 16'h0000;
    r[PIR_ADV_NEXT_PAGE_BIT] = 1'h0;
    r[PIR_ADV_ACK_BIT] = ack;
    r[PIR_ADV_RF_BIT]  = rf;
    r[PIR_ADV_RSV_MSB:PIR_ADV_RSV_LSB] = rsv;
    r[PIR_ADV_FC_BIT]  = fc;
    r[PIR_ADV_T4_BIT]  = 1'h0;
    r[PIR_ADV_ABIL_MSB:PIR_ADV_ABIL_LSB] = abil;
    r[PIR_ADV_SEL_MSB:PIR_ADV_SEL_LSB]   = sel;
    return r;
  endfunction : adv_word_f

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic mdc_lvl;
  logic mdio_lvl;

  pir_pin_sync #(.RST_VAL(1'h0)) u_mdc_sync (
    .clk_in    (SYS_CLK_IN),
    .rstn_in   (RSTN_IN),
    .pin_in    (MDC_IN),
    .level_out (mdc_lvl)
  );

  // MDIO idles high on its pull-up, so start there
  pir_pin_sync #(.RST_VAL(1'h1)) u_mdio_sync (
    .clk_in    (SYS_CLK_IN),
    .rstn_in   (RSTN_IN),
    .pin_in    (MDIO_IN),
    .level_out (mdio_lvl)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pir_state_t  st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [11:0] hdr_q, hdr_d;
  logic [15:0] data_q, data_d;
  logic        mdc_prev_q, mdio_o_q, mdio_o_d, oe_q, oe_d;
  logic        rf_q, rf_d, fc_q, fc_d;
  logic [1:0]  rsv_q, rsv_d;
  logic [3:0]  abil_q, abil_d;
  logic [4:0]  sel_q, sel_d;
  logic [15:0] adv_q, adv_d;
  logic        mdc_rise;
  logic [11:0] hdr_full;
  logic [15:0] wr_word;

  // MDIO is sampled on the filtered rising edge of MDC
  assign mdc_rise = mdc_lvl & ~mdc_prev_q;
  assign hdr_full = {hdr_q[10:0], mdio_lvl};
  assign wr_word  = {data_q[14:0], mdio_lvl};

  // ----------------------------------------------------------------
  // Frame engine and register next values
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    hdr_d    = hdr_q;
    data_d   = data_q;
    mdio_o_d = mdio_o_q;
    oe_d     = oe_q;
    rf_d     = rf_q;
    rsv_d    = rsv_q;
    fc_d     = fc_q;
    abil_d   = abil_q;
    sel_d    = sel_q;
    if (mdc_rise) begin
      case (st_q)
        ST_PRE: begin
          if (mdio_lvl) begin
            cnt_d = (cnt_q == PIR_PRE_ONES) ? cnt_q : cnt_q + 6'h01;
          end else if (cnt_q == PIR_PRE_ONES) begin
            st_d  = ST_START;
            cnt_d = 6'h00;
          end else begin
            cnt_d = 6'h00;
          end
        end
        ST_START: begin
          st_d  = mdio_lvl ? ST_HDR : ST_PRE;
          cnt_d = 6'h00;
        end
        ST_HDR: begin
          hdr_d = hdr_full;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == PIR_HDR_LAST) begin
            cnt_d = 6'h00;
            st_d  = ST_PRE;
            // Other addresses are left for the rest of the bank to answer
            if (hdr_full[9:5] == PHY_ADDR) begin
              if (hdr_full[11:10] == PIR_OP_READ) begin
                if (hdr_full[4:0] == PIR_REG_ID_HIGH) begin
                  st_d   = ST_TA_RD;
                  data_d = id_high_w;
                end else if (hdr_full[4:0] == PIR_REG_ID_LOW) begin
                  st_d   = ST_TA_RD;
                  data_d = id_low_w;
                end else if (hdr_full[4:0] == PIR_REG_ADVERT) begin
                  st_d   = ST_TA_RD;
                  data_d = adv_q;
                end
              end else if (hdr_full[11:10] == PIR_OP_WRITE) begin
                st_d = ST_TA_WR;
              end
            end
          end
        end
        ST_TA_RD: begin
          // Second turnaround bit: take the line, drive zero
          oe_d     = 1'h1;
          mdio_o_d = 1'h0;
          st_d     = ST_RD;
          cnt_d    = 6'h00;
        end
        ST_RD: begin
          mdio_o_d = data_q[15];
          data_d   = {data_q[14:0], 1'h0};
          cnt_d    = cnt_q + 6'h01;
          if (cnt_q == PIR_DATA_END) begin
            oe_d     = 1'h0;
            mdio_o_d = 1'h0;
            st_d     = ST_PRE;
            cnt_d    = 6'h00;
          end
        end
        ST_TA_WR: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == PIR_TA_LAST) begin
            st_d  = ST_WR;
            cnt_d = 6'h00;
          end
        end
        ST_WR: begin
          data_d = wr_word;
          cnt_d  = cnt_q + 6'h01;
          if (cnt_q == PIR_DATA_LAST) begin
            st_d  = ST_PRE;
            cnt_d = 6'h00;
            // Identifiers ignore writes; bits 15, 14, 9 are not stored
            if (hdr_q[4:0] == PIR_REG_ADVERT) begin
              rf_d   = wr_word[PIR_ADV_RF_BIT];
              rsv_d  = wr_word[PIR_ADV_RSV_MSB:PIR_ADV_RSV_LSB];
              fc_d   = wr_word[PIR_ADV_FC_BIT];
              abil_d = wr_word[PIR_ADV_ABIL_MSB:PIR_ADV_ABIL_LSB];
              sel_d  = wr_word[PIR_ADV_SEL_MSB:PIR_ADV_SEL_LSB];
            end
          end
        end
        default: begin
          st_d  = ST_PRE;
          cnt_d = 6'h00;
        end
      endcase
    end
    // Transceiver reset wins over a write landing in the same cycle
    if (PHY_SOFT_RST_IN) begin
      rf_d   = PIR_RF_RST;
      rsv_d  = PIR_RSV_RST;
      fc_d   = PIR_FC_RST;
      abil_d = PIR_ABIL_RST;
      sel_d  = PIR_SEL_RST;
    end
    adv_d = adv_word_f(AN_ACK_IN, rf_d, rsv_d, fc_d, abil_d, sel_d);
  end

  // Registers only; chip reset restores every field default but clears the advertised word to zero
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      st_q       <= ST_PRE;
      cnt_q      <= 6'h00;
      hdr_q      <= 12'h000;
      data_q     <= 16'h0000;
      mdc_prev_q <= 1'h0;
      mdio_o_q   <= 1'h0;
      oe_q       <= 1'h0;
      rf_q       <= PIR_RF_RST;
      rsv_q      <= PIR_RSV_RST;
      fc_q       <= PIR_FC_RST;
      abil_q     <= PIR_ABIL_RST;
      sel_q      <= PIR_SEL_RST;
      adv_q      <= 16'h0000;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      hdr_q      <= hdr_d;
      data_q     <= data_d;
      mdc_prev_q <= mdc_lvl;
      mdio_o_q   <= mdio_o_d;
      oe_q       <= oe_d;
      rf_q       <= rf_d;
      rsv_q      <= rsv_d;
      fc_q       <= fc_d;
      abil_q     <= abil_d;
      sel_q      <= sel_d;
      adv_q      <= adv_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign MDIO_OUT     = mdio_o_q;
  assign MDIO_OE_OUT  = oe_q;
  assign ADV_WORD_OUT = adv_q;

endmodule : pir_phy_id_advert
`default_nettype wire

// [pir_pkg.sv]
// Constants, field layout and frame figures for the identifier and
// advertisement register block of the 10/100 transceiver.
// Assumes a clause-22 style serial management frame on the MAC side.
package pir_pkg;

  // ----------------------------------------------------------------
  // Register numbers on the management interface
  // ----------------------------------------------------------------
  localparam logic [4:0] PIR_REG_ID_HIGH = 5'h02;
  localparam logic [4:0] PIR_REG_ID_LOW  = 5'h03;
  localparam logic [4:0] PIR_REG_ADVERT  = 5'h04;

  // ----------------------------------------------------------------
  // Advertisement register field positions
  // ----------------------------------------------------------------
  localparam int PIR_ADV_NEXT_PAGE_BIT = 15;
  localparam int PIR_ADV_ACK_BIT       = 14;
  localparam int PIR_ADV_RF_BIT        = 13;
  localparam int PIR_ADV_RSV_MSB       = 12;
  localparam int PIR_ADV_RSV_LSB       = 11;
  localparam int PIR_ADV_FC_BIT        = 10;
  localparam int PIR_ADV_T4_BIT        = 9;
  localparam int PIR_ADV_ABIL_MSB      = 8;
  localparam int PIR_ADV_ABIL_LSB      = 5;
  localparam int PIR_ADV_SEL_MSB       = 4;
  localparam int PIR_ADV_SEL_LSB       = 0;

  // ----------------------------------------------------------------
  // Advertisement reset values
  // ----------------------------------------------------------------
  localparam logic       PIR_RF_RST   = 1'h0;
  localparam logic [1:0] PIR_RSV_RST  = 2'h0;
  localparam logic       PIR_FC_RST   = 1'h0;
  localparam logic [3:0] PIR_ABIL_RST = 4'hf;
  localparam logic [4:0] PIR_SEL_RST  = 5'h01;

  // ----------------------------------------------------------------
  // Identifier layout (org code bits numbered 1..24)
  // ----------------------------------------------------------------
  localparam int PIR_ORG_HIGH_FIRST = 3;
  localparam int PIR_ORG_LOW_FIRST  = 19;
  localparam int PIR_ORG_LOW_BITS   = 6;
  localparam int PIR_MODEL_LSB      = 4;
  localparam int PIR_REV_LSB        = 0;
  // Identity defaults: arbitrary values, not any real part
  localparam logic [23:0] PIR_ORG_CODE_DEF  = 24'h5a3c81;
  localparam logic [5:0]  PIR_MODEL_NUM_DEF = 6'h15;
  localparam logic [3:0]  PIR_MODEL_REV_DEF = 4'h3;
  localparam logic [4:0]  PIR_PHY_ADDR_DEF  = 5'h01;

  // ----------------------------------------------------------------
  // Management frame figures
  // ----------------------------------------------------------------
  localparam logic [5:0] PIR_PRE_ONES  = 6'h20;
  localparam logic [5:0] PIR_HDR_LAST  = 6'h0b;
  localparam logic [5:0] PIR_TA_LAST   = 6'h01;
  localparam logic [5:0] PIR_DATA_LAST = 6'h0f;
  localparam logic [5:0] PIR_DATA_END  = 6'h10;
  localparam logic [1:0] PIR_OP_READ   = 2'h2;
  localparam logic [1:0] PIR_OP_WRITE  = 2'h1;

  typedef enum logic [2:0] {
    ST_PRE, ST_START, ST_HDR, ST_TA_RD, ST_TA_WR, ST_RD, ST_WR
  } pir_state_t;

endpackage : pir_pkg

// [pir_pin_sync.sv]
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is slow against the system clock (several cycles a level).
`timescale 1ns/1ps
`default_nettype none
module pir_pin_sync #(
  parameter logic RST_VAL = 1'h0
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;

  // --------------------------------------------------------------
  // Filter: follow only when stages two and three agree
  // --------------------------------------------------------------
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule : pir_pin_sync
`default_nettype wire

// [pir_phy_id_advert_assertions.sv]
// Port checker for the identifier and advertisement register block.
// Assumes an MDC half period of at least 8 system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module pir_phy_id_advert_assertions (
  // Clock and resets
  input wire logic        SYS_CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        PHY_SOFT_RST_IN,
  // Management pins
  input wire logic        MDC_IN,
  input wire logic        MDIO_IN,
  input wire logic        MDIO_OUT,
  input wire logic        MDIO_OE_OUT,
  // Negotiation engine side
  input wire logic        AN_ACK_IN,
  input wire logic [15:0] ADV_WORD_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  logic       mdc_q;
  logic [4:0] oe_rises_q;
  logic [5:0] since_rise_q;

  // Pin rises seen while driving, and idle time since the last rise
  always_ff @(posedge SYS_CLK_IN) begin
    mdc_q <= MDC_IN;
    if (!RSTN_IN || !MDIO_OE_OUT) oe_rises_q <= 5'h00;
    else if (MDC_IN && !mdc_q) oe_rises_q <= oe_rises_q + 5'h01;
    if (!RSTN_IN) since_rise_q <= 6'h3f;
    else if (MDC_IN && !mdc_q) since_rise_q <= 6'h00;
    else if (since_rise_q != 6'h3f) since_rise_q <= since_rise_q + 6'h01;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_NEXT_PAGE_ZERO: assert property (ADV_WORD_OUT[15] == 1'b0)
    else $error("next page bit set in advertised word");
  AST_T4_ZERO: assert property (ADV_WORD_OUT[9] == 1'b0)
    else $error("four-pair bit set in advertised word");
  AST_ACK_FOLLOWS: assert property ($past(RSTN_IN) |-> ADV_WORD_OUT[14] == $past(AN_ACK_IN))
    else $error("acknowledge bit does not follow engine");
  AST_RESET_DEFAULT: assert property ($rose(RSTN_IN) |=> (ADV_WORD_OUT & 16'hbfff) == 16'h01e1)
    else $error("advert word not default after reset");
  AST_SOFT_DEFAULT: assert property (PHY_SOFT_RST_IN [*2] |=> (ADV_WORD_OUT & 16'hbfff) == 16'h01e1)
    else $error("advert word not default after soft reset");
  AST_TA_LOW: assert property ($rose(MDIO_OE_OUT) |-> !MDIO_OUT)
    else $error("turnaround bit not driven low");
  AST_DRIVE_LEN: assert property ($fell(MDIO_OE_OUT) |-> oe_rises_q == 5'h11)
    else $error("read drive not seventeen clock periods");
  // Stored fields change only by a frame or a soft reset; the word loads its
  // defaults one edge after reset is released, so look two edges back too
  AST_WORD_CAUSE: assert property ($changed(ADV_WORD_OUT & 16'hbfff) |->
    (!$past(RSTN_IN) || !$past(RSTN_IN, 2) || $past(PHY_SOFT_RST_IN) ||
     $past(PHY_SOFT_RST_IN, 2) || since_rise_q < 6'h10))
    else $error("advert word changed without cause");

  COV_READ: cover property ($rose(MDIO_OE_OUT));
  COV_SOFT: cover property ($fell(PHY_SOFT_RST_IN));
  COV_WRITE: cover property ($changed(ADV_WORD_OUT & 16'hbfff));
endmodule : pir_phy_id_advert_assertions
`default_nettype wire

// [pir_mgmt_master.sv]
// Station management controller model driving MDC and MDIO.
// Assumes the bench resolves the MDIO wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module pir_mgmt_master
  import pir_pkg::*;
#(
  parameter int HALF_NS = 400
) (
  output logic      mdc_out,
  output logic      mdio_en_out,
  output logic      mdio_val_out,
  input  wire logic mdio_line_in
);
  initial begin
    mdc_out = 1'b0;
    mdio_en_out = 1'b0;
    mdio_val_out = 1'b1;
  end

  // One frame; data changes while MDC is low, read data taken before each rise
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, phy, ra, (op == PIR_OP_WRITE) ? {2'b10, wd[15:13], 2'b00, wd[10:0]} : 18'h0};
    rd = 16'h0000;
    for (int k = 0; k < pre + 33; k++) begin
      mdio_en_out = (k < pre + 14) || (op == PIR_OP_WRITE && k < pre + 32);
      mdio_val_out = (k < pre || k >= pre + 32) ? 1'b1 : bits[31 - (k - pre)];
      #(HALF_NS);
      // Sixteen data bits only, the last one just before the rise at which the transceiver releases the line
      if (k >= pre + 16 && k < pre + 32) rd = {rd[14:0], mdio_line_in};
      mdc_out = 1'b1;
      #(HALF_NS);
      mdc_out = 1'b0;
    end
    mdio_en_out = 1'b0; // Clock stands still between frames
  endtask : frame
endmodule : pir_mgmt_master
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the identifier and advertisement registers.
// Assumes the management model and the port checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pir_pkg::*;
  logic        sys_clk, rstn, soft_rst, an_ack, mdio_out, mdio_oe;
  logic        m_mdc, m_en, m_val, mdio_line, oe_seen;
  logic [15:0] adv_word, rd, w;
  int          miscompares, check_count;

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  // Pull-up holds the data wire when nobody drives it
  assign mdio_line = mdio_oe ? mdio_out : (m_en ? m_val : 1'b1);
  always @(posedge sys_clk) if (mdio_oe === 1'b1) oe_seen <= 1'b1;

  pir_phy_id_advert pir_phy_id_advert_inst (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn), .PHY_SOFT_RST_IN(soft_rst),
    .MDC_IN(m_mdc), .MDIO_IN(mdio_line), .MDIO_OUT(mdio_out), .MDIO_OE_OUT(mdio_oe),
    .AN_ACK_IN(an_ack), .ADV_WORD_OUT(adv_word));
  pir_mgmt_master pir_mgmt_master_inst (.mdc_out(m_mdc), .mdio_en_out(m_en), .mdio_val_out(m_val),
    .mdio_line_in(mdio_line));

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] id_high_exp();
    logic [15:0] r;
    for (int k = 0; k < 16; k++) r[15 - k] = PIR_ORG_CODE_DEF[2 + k];
    return r;
  endfunction : id_high_exp
  function automatic logic [15:0] id_low_exp();
    logic [15:0] r;
    for (int k = 0; k < 6; k++) r[15 - k] = PIR_ORG_CODE_DEF[18 + k];
    r[9:0] = {PIR_MODEL_NUM_DEF, PIR_MODEL_REV_DEF};
    return r;
  endfunction : id_low_exp
  // Reserved bits are always sent as zero, so they never show here
  function automatic logic [15:0] adv_exp(input logic [15:0] wv, input logic ack);
    return (wv & 16'h25ff) | {1'b0, ack, 14'h0000};
  endfunction : adv_exp
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic xfer(input int pre, input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd);
    @(negedge sys_clk) oe_seen = 1'b0;
    pir_mgmt_master_inst.frame(pre, op, phy, ra, wd, rd);
    repeat (20) @(negedge sys_clk);
  endtask : xfer
  task automatic complete_run();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    soft_rst = 1'b0;
    an_ack = 1'b0;
    oe_seen = 1'b0;
    miscompares = 0;
    check_count = 0;
    void'($urandom(44));
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk("adv after reset", 16'h01e1, adv_word);
    xfer(32, PIR_OP_READ, PIR_PHY_ADDR_DEF, PIR_REG_ID_HIGH, 16'h0000);
    chk("id high", id_high_exp(), rd);
    xfer(32, PIR_OP_WRITE, PIR_PHY_ADDR_DEF, PIR_REG_ID_LOW, 16'hffff);
    xfer(32, PIR_OP_READ, PIR_PHY_ADDR_DEF, PIR_REG_ID_LOW, 16'h0000);
    chk("id low", id_low_exp(), rd);
    // Corners first, then random words with a random acknowledge
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      an_ack = 1'($urandom);
      xfer(32, PIR_OP_WRITE, PIR_PHY_ADDR_DEF, PIR_REG_ADVERT, w);
      chk("adv word", adv_exp(w, an_ack), adv_word);
      xfer(32, PIR_OP_READ, PIR_PHY_ADDR_DEF, PIR_REG_ADVERT, 16'h0000);
      chk("adv read", adv_exp(w, an_ack), rd);
    end
    xfer(20, PIR_OP_WRITE, PIR_PHY_ADDR_DEF, PIR_REG_ADVERT, ~w);
    chk("adv short preamble", adv_exp(w, an_ack), adv_word);
    xfer(32, PIR_OP_READ, 5'h1e, PIR_REG_ADVERT, 16'h0000);
    chk("other address", 16'hffff, rd);
    chk("other address drive", 16'h0000, {15'h0000, oe_seen});
    xfer(32, PIR_OP_READ, PIR_PHY_ADDR_DEF, 5'h05, 16'h0000);
    chk("unmapped drive", 16'h0000, {15'h0000, oe_seen});
    // Opcode that is neither read nor write must be ignored
    xfer(32, 2'b11, PIR_PHY_ADDR_DEF, PIR_REG_ADVERT, 16'h0000);
    chk("bad opcode drive", 16'h0000, {15'h0000, oe_seen});
    soft_rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    soft_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("adv soft reset", adv_exp(16'h01e1, an_ack), adv_word);
    xfer(32, PIR_OP_READ, PIR_PHY_ADDR_DEF, PIR_REG_ID_HIGH, 16'h0000);
    chk("id high kept", id_high_exp(), rd);
    complete_run();
  end

  // Watchdog at about twice the length of the twenty frames of the run
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule : tb_top

bind pir_phy_id_advert pir_phy_id_advert_assertions pir_phy_id_advert_assertions_inst (
  .SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .PHY_SOFT_RST_IN(PHY_SOFT_RST_IN), .MDC_IN(MDC_IN),
  .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT), .MDIO_OE_OUT(MDIO_OE_OUT), .AN_ACK_IN(AN_ACK_IN),
  .ADV_WORD_OUT(ADV_WORD_OUT));
`default_nettype wire
